// file: rtl/pwm_cfg_defs.svh
// Constants for the PWM configuration and write-protect block.
// Assumes a byte-offset register map reached over 32-bit classic Wishbone.
`ifndef PWM_CFG_DEFS_SVH
`define PWM_CFG_DEFS_SVH
`define CFG0_OFFSET      8'h00
`define WIN_LO_OFFSET    8'h20
`define WIN_HI_OFFSET    8'h27
`define GEN_LO_OFFSET    8'h28
`define GEN_HI_OFFSET    8'h37
`define BIT_PROTECT      7
`define BIT_MULTI_TB     6
`define BIT_ALIGN_C      5
`define BIT_ALIGN_B      4
`define BIT_ALIGN_A      3
`define BIT_SEP_C        2
`define BIT_SEP_B        1
`define BIT_SEP_A        0
`define CFG0_RESET       8'h00
`define REG_RESET        8'h00
`endif

// file: rtl/pwm_cfg_pkg.sv
// Types shared by the PWM configuration block.
// Assumes the constants header is included alongside.
package pwm_cfg_pkg;
    typedef logic [7:0] byte_type;
    typedef logic [7:0] addr_type;
endpackage : pwm_cfg_pkg

// file: rtl/pwm_config_write_protect.sv
// First configuration register of a three-pair PWM module, with write protection.
// Assumes a classic Wishbone master on clk_i; registers are byte offsets, data in bits 7:0.
//
// Behaviour
// - Bit 7 write-once protect latch, reset clears
// - Config register always readable, locked after protect
// - Bit 6 selects single or multiple timebases
// - Multiple timebases enable generator B/C range
// - Single timebase: B/C range ignores writes, reads zero
// - Single timebase: all pairs follow generator A
// - Bit 5 aligns pair C, multi only
// - Bit 4 aligns pair B, multi only
// - Bit 3 aligns pair A, and B/C when single
// - Bit 2 separates channels 4 and 5
// - Bit 1 separates channels 2 and 3
// - Bit 0 separates channels 0 and 1
`timescale 1ns/100ps
`include "pwm_cfg_defs.svh"

module pwm_config_write_protect
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [3:0]            sel_i,
    input  wire pwm_cfg_pkg::addr_type adr_i,
    input  wire logic [31:0]           dat_i,
    output logic      [31:0]           dat_o,
    output logic                       ack_o,
    output logic                       protect_o,
    output logic                       multi_timebase_sel_o,
    output logic                       align_sel_pair_a_o,
    output logic                       align_sel_pair_b_o,
    output logic                       align_sel_pair_c_o,
    output logic                       separate_mode_pair_a_o,
    output logic                       separate_mode_pair_b_o,
    output logic                       separate_mode_pair_c_o,
    output logic                       gen_bc_enable_o
);
    import pwm_cfg_pkg::*;

    localparam int GEN_WORDS = 16;

    byte_type     cfg_q;
    byte_type     gen_q [GEN_WORDS];
    logic         ack_q;
    logic  [31:0] dat_q;

    // Register storage for the generator B/C range; its meaning lives elsewhere.
    wire logic    req        = cyc_i && stb_i && !ack_q;
    wire logic    hit_cfg    = (adr_i == `CFG0_OFFSET);
    wire logic    hit_gen    = (adr_i >= `GEN_LO_OFFSET) && (adr_i <= `GEN_HI_OFFSET);
    wire logic    locked     = cfg_q[`BIT_PROTECT];
    wire logic    multi      = cfg_q[`BIT_MULTI_TB];
    wire logic [3:0] gen_idx = 4'(adr_i - `GEN_LO_OFFSET);
    // The lock is never released by a write, only by reset.
    wire logic    wr_cfg     = req && we_i && sel_i[0] && hit_cfg && !locked;
    wire logic    wr_gen     = req && we_i && sel_i[0] && hit_gen && multi;
    wire byte_type rd_byte   = hit_cfg ? cfg_q
                             : (hit_gen && multi) ? gen_q[gen_idx]
                             : `REG_RESET;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_q <= `CFG0_RESET;
        end
        else if (wr_cfg)
        begin
            cfg_q <= dat_i[7:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < GEN_WORDS; g++)
        begin : gen_store
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    gen_q[g] <= `REG_RESET;
                end
                else if (wr_gen && gen_idx == 4'(g))
                begin
                    gen_q[g] <= dat_i[7:0];
                end
            end
        end
    endgenerate

    // One-cycle ack, registered one cycle after the request; every address answers, so no access ever errors.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= req;
            dat_q <= {24'h00_0000, rd_byte};
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

    // Single timebase forces pairs B and C onto pair A's alignment.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            protect_o              <= 1'b0;
            multi_timebase_sel_o   <= 1'b0;
            align_sel_pair_a_o     <= 1'b0;
            align_sel_pair_b_o     <= 1'b0;
            align_sel_pair_c_o     <= 1'b0;
            separate_mode_pair_a_o <= 1'b0;
            separate_mode_pair_b_o <= 1'b0;
            separate_mode_pair_c_o <= 1'b0;
            gen_bc_enable_o        <= 1'b0;
        end
        else
        begin
            protect_o              <= locked;
            multi_timebase_sel_o   <= multi;
            align_sel_pair_a_o     <= cfg_q[`BIT_ALIGN_A];
            align_sel_pair_b_o     <= multi ? cfg_q[`BIT_ALIGN_B] : cfg_q[`BIT_ALIGN_A];
            align_sel_pair_c_o     <= multi ? cfg_q[`BIT_ALIGN_C] : cfg_q[`BIT_ALIGN_A];
            separate_mode_pair_a_o <= cfg_q[`BIT_SEP_A];
            separate_mode_pair_b_o <= cfg_q[`BIT_SEP_B];
            separate_mode_pair_c_o <= cfg_q[`BIT_SEP_C];
            gen_bc_enable_o        <= multi;
        end
    end
endmodule : pwm_config_write_protect

// file: sim/pwm_cfg_monitor.sv
// Checker for the PWM config block, bound to each instance.
// Assumes one clock with a synchronous reset.
`timescale 1ns/100ps
module pwm_cfg_monitor
(
    input wire logic clk_i, rst_i, cyc_i, stb_i, ack_o, protect_o,
    input wire logic multi_timebase_sel_o, gen_bc_enable_o, align_sel_pair_a_o,
    input wire logic align_sel_pair_b_o, align_sel_pair_c_o
);
    wire req = cyc_i & stb_i & !ack_o;
    wire mt = multi_timebase_sel_o;
    wire aa = align_sel_pair_a_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; req |=> ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_one; ack_o |=> !ack_o; endproperty
    a_one: assert property (p_one) else $error("long ack");
    // The reset edge itself clears the latch, so an attempt started there is excluded.
    property p_hold; protect_o && !rst_i |=> protect_o; endproperty
    a_hold: assert property (p_hold) else $error("lock lost");
    property p_lock; protect_o && !rst_i |=> $stable(mt); endproperty
    a_lock: assert property (p_lock) else $error("lock broken");
    property p_gen; gen_bc_enable_o == mt; endproperty
    a_gen: assert property (p_gen) else $error("gen enable");
    property p_pb; !mt |-> align_sel_pair_b_o == aa; endproperty
    a_pb: assert property (p_pb) else $error("pair b");
    property p_pc; !mt |-> align_sel_pair_c_o == aa; endproperty
    a_pc: assert property (p_pc) else $error("pair c");
    property p_up; $rose(protect_o) |-> $past(ack_o); endproperty
    a_up: assert property (p_up) else $error("lock rose");
endmodule : pwm_cfg_monitor
bind pwm_config_write_protect pwm_cfg_monitor u_mon (.*);

// file: sim/pwm_config_write_protect_tb_top.sv
// Bench for the PWM config block: table rows, then a mid-run reset.
// Assumes the checker binds itself to DUT.
`timescale 1ns/100ps
module pwm_config_write_protect_tb_top;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h1;
    logic [31:0] dat_i = 32'h0000_0000, dat_o;
    logic [8:0] st;
    int error_cnt = 0, n_checks = 0;
    // Write flag, address, data, read value, status after.
    logic [39:0] t [12] = '{40'h10_02D0_007A, 40'h00_0002_D07A, 40'h12_8A50_007A,
        40'h02_8000_007A, 40'h10_0560_00AD, 40'h00_0005_60AD, 40'h13_75A0_00AD,
        40'h03_7005_A0AD, 40'h04_0000_00AD, 40'h10_0D60_01AD, 40'h10_0000_01AD,
        40'h00_000D_61AD};
    pwm_config_write_protect DUT (.*, .protect_o(st[8]),
        .multi_timebase_sel_o(st[7]), .align_sel_pair_c_o(st[6]), .align_sel_pair_b_o(st[5]),
        .align_sel_pair_a_o(st[4]), .separate_mode_pair_c_o(st[3]),
        .separate_mode_pair_b_o(st[2]), .separate_mode_pair_a_o(st[1]), .gen_bc_enable_o(st[0]));
    always #10 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] g, e);
        n_checks++;
        error_cnt += int'(g !== e);
        if (g !== e) $display("MISMATCH %0t got %h", $time, g);
    endtask : chk
    // Read data is taken at the ack edge itself; dat_o is reloaded every cycle from the held address.
    task automatic wb(input logic w, input logic [7:0] a, d, e);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h00_0000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        if (!w) chk(dat_o, {24'h00_0000, e});
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask : wb
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    initial
    begin
        repeat (2000) @(posedge clk_i);
        error_cnt++;
        results();
    end
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        foreach (t[i])
        begin
            wb(t[i][36], t[i][35:28], t[i][27:20], t[i][19:12]);
            chk(st, t[i][11:0]);
        end
        $display("rows end");
        rst_i <= 1;
        @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        chk(st, 9'h000);
        wb(1'b0, 8'h00, 8'h00, 8'h00);
        sel_i <= 4'h0;
        wb(1'b1, 8'h00, 8'hFF, 8'h00);
        sel_i <= 4'h1;
        wb(1'b0, 8'h00, 8'h00, 8'h00);
        chk(st, 9'h000);
        $display("reset end");
        results();
    end
endmodule : pwm_config_write_protect_tb_top
